// ---- hw/addr_cfg_pkg.sv ----
// Constants for the bus address configuration latch
package addr_cfg_pkg;
  // ==========================================================
  // Register map (AXI4-Lite byte addresses)
  localparam logic [3:0] cfg_reg_off    = 4'h0;
  localparam logic [3:0] status_reg_off = 4'h4;
  localparam logic [3:0] raw_reg_off    = 4'h8;
  localparam logic [3:0] ctrl_reg_off   = 4'hc;
  // ==========================================================
  // Address field values
  localparam logic [4:0] addr_invalid    = 5'h1f;
  localparam logic [4:0] addr_substitute = 5'h1e;
  localparam logic [4:0] addr_reset      = 5'h00;
  // ==========================================================
  // Bus address character bases (listen 0x20, talk 0x40)
  localparam logic [7:0] listen_base = 8'h20;
  localparam logic [7:0] talk_base   = 8'h40;
  // ==========================================================
  // Field positions in the status word
  localparam int addr_lsb_pos   = 0;
  localparam int listen_pos     = 8;
  localparam int talk_pos       = 9;
  localparam int addressed_pos  = 10;
  localparam int latched_pos    = 11;
  localparam int listen_chr_pos = 16;
  localparam int talk_chr_pos   = 24;
  // ==========================================================
  // Timing: switch settle time before the sample is taken
  localparam int settle_ns     = 1000;
  localparam int clk_period_ns = 10;
  localparam int settle_cycles = (settle_ns + clk_period_ns - 1) / clk_period_ns;
  // ==========================================================
  // Bus answers
  localparam logic [1:0] resp_okay   = 2'h0;
  localparam logic [1:0] resp_slverr = 2'h2;
  // Operating modes
  typedef enum logic [2:0] {
    mode_addressed   = 3'b001,
    mode_listen_only = 3'b010,
    mode_talk_only   = 3'b100
  } mode_t;
  // Power-up sequencer states
  typedef enum logic [2:0] {
    st_settle = 3'b001,
    st_sample = 3'b010,
    st_run    = 3'b100
  } pwr_state_t;
endpackage

// ---- hw/switch_sync.sv ----
// Two-stage synchroniser for the rear-panel switch pins
`timescale 1ns/1ps
module switch_sync #(
  parameter int width = 7
) (
  input  wire logic             clk_in,
  input  wire logic             sys_rst_in,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);
  logic [width-1:0] stage1;

  // ==========================================================
  // Two flip-flops; first stage feeds only the second
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule

// ---- hw/bus_address_config_latch.sv ----
// Power-up latch of bus address and listen/talk-only selectors, AXI4-Lite view
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module bus_address_config_latch (
  input  wire logic        clk_in,
  input  wire logic        sys_rst_in,
  // Rear-panel switches (asynchronous pins)
  input  wire logic        addr_switch_lsb_in,
  input  wire logic [2:0]  addr_switch_mid_in,
  input  wire logic        addr_switch_msb_in,
  input  wire logic        listen_only_select_in,
  input  wire logic        talk_only_select_in,
  // Configuration results
  output logic [4:0]       bus_address_out,
  output logic [7:0]       listen_char_out,
  output logic [7:0]       talk_char_out,
  output logic             listen_only_out,
  output logic             talk_only_out,
  output logic             addressed_out,
  output logic             config_valid_out,
  // AXI4-Lite slave
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  // ==========================================================
  // Declarations
  logic [6:0]                       sw_sync;
  logic [4:0]                       raw_addr;
  logic                             raw_lo;
  logic                             raw_to;
  addr_cfg_pkg::pwr_state_t         state;
  logic [15:0]                      settle_cnt;
  logic [4:0]                       stored_addr;
  addr_cfg_pkg::mode_t              mode;
  logic                             addr_clamped;
  logic                             bus_enable;
  logic                             aw_held;
  logic                             w_held;
  logic [3:0]                       aw_addr_q;
  logic [31:0]                      w_data_q;
  logic [3:0]                       w_strb_q;
  logic [31:0]                      status_word;
  logic [31:0]                      next_rdata;
  logic [1:0]                       next_rresp;
  logic [1:0]                       next_bresp;
  logic                             wr_fire;

  // ==========================================================
  // Helper functions
  // Replace the one invalid switch code with the top valid address
  // Only code 31 is replaced; every other switch code passes through
  function automatic logic [4:0] clamp_addr(input logic [4:0] a);
    clamp_addr = (a == addr_cfg_pkg::addr_invalid) ? addr_cfg_pkg::addr_substitute : a;
  endfunction

  // Character on the bus for a given base and address
  // The low five bits of both characters carry the address
  function automatic logic [7:0] addr_char(input logic [7:0] base, input logic [4:0] a);
    addr_char = base | {3'h0, a};
  endfunction

  // ==========================================================
  // Switch pins pass two flip-flops before use
  // Bit order on the synchroniser: talk, listen, msb, mid, lsb
  switch_sync #(
    .width(7)
  ) u_sync (
    .clk_in    (clk_in),
    .sys_rst_in(sys_rst_in),
    .async_in  ({talk_only_select_in, listen_only_select_in, addr_switch_msb_in,
                 addr_switch_mid_in, addr_switch_lsb_in}),
    .sync_out  (sw_sync)
  );

  // Set switch is 1, cleared is 0; bit 0 is the first switch
  assign raw_addr = sw_sync[4:0];
  assign raw_lo   = sw_sync[5];
  assign raw_to   = sw_sync[6];

  // ==========================================================
  // Power-up sequencer: settle, take one sample, then hold forever
  // Settle window lets the synchroniser and switch contacts come to rest
  // Run state has no exit: only a power-up reset opens a new sample
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      state      <= addr_cfg_pkg::st_settle;
      settle_cnt <= '0;
    end else begin
      case (state)
        addr_cfg_pkg::st_settle: begin
          if (settle_cnt == 16'(addr_cfg_pkg::settle_cycles - 1)) begin
            state <= addr_cfg_pkg::st_sample;
          end else begin
            settle_cnt <= settle_cnt + 16'h0001;
          end
        end
        addr_cfg_pkg::st_sample: begin
          state <= addr_cfg_pkg::st_run;
        end
        addr_cfg_pkg::st_run: begin
          state <= addr_cfg_pkg::st_run;
        end
        default: begin
          state <= addr_cfg_pkg::st_settle;
        end
      endcase
    end
  end

  // ==========================================================
  // Latched configuration, written once in the sample state
  // Clamp flag kept so software can see that the switches read 31
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      stored_addr  <= addr_cfg_pkg::addr_reset;
      mode         <= addr_cfg_pkg::mode_addressed;
      addr_clamped <= 1'b0;
    end else if (state == addr_cfg_pkg::st_sample) begin
      stored_addr  <= clamp_addr(raw_addr);
      addr_clamped <= (raw_addr == addr_cfg_pkg::addr_invalid);
      // Listen-only has fixed priority over talk-only
      if (raw_lo) begin
        mode <= addr_cfg_pkg::mode_listen_only;
      end else if (raw_to) begin
        mode <= addr_cfg_pkg::mode_talk_only;
      end else begin
        mode <= addr_cfg_pkg::mode_addressed;
      end
    end
  end

  // ==========================================================
  // Software bus enable, default on
  // Gates only the mode pins; the latched mode itself is never rewritten
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_enable <= 1'b1;
    end else if (wr_fire && aw_addr_q == addr_cfg_pkg::ctrl_reg_off && w_strb_q[0]) begin
      bus_enable <= w_data_q[0];
    end
  end

  // ==========================================================
  // Registered outputs
  // One cycle behind the stored values, so they settle as config_valid rises
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      bus_address_out  <= addr_cfg_pkg::addr_reset;
      listen_char_out  <= 8'h00;
      talk_char_out    <= 8'h00;
      listen_only_out  <= 1'b0;
      talk_only_out    <= 1'b0;
      addressed_out    <= 1'b0;
      config_valid_out <= 1'b0;
    end else begin
      bus_address_out  <= stored_addr;
      listen_char_out  <= addr_char(addr_cfg_pkg::listen_base, stored_addr);
      talk_char_out    <= addr_char(addr_cfg_pkg::talk_base, stored_addr);
      listen_only_out  <= bus_enable && (mode == addr_cfg_pkg::mode_listen_only);
      talk_only_out    <= bus_enable && (mode == addr_cfg_pkg::mode_talk_only);
      // Address used only in addressed mode
      addressed_out    <= bus_enable && (mode == addr_cfg_pkg::mode_addressed)
                          && (state == addr_cfg_pkg::st_run);
      config_valid_out <= (state == addr_cfg_pkg::st_run);
    end
  end

  // ==========================================================
  // Status word assembly
  // Mode bits ignore the bus enable so software sees the latched choice
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[addr_cfg_pkg::addr_lsb_pos +: 5] = stored_addr;
    status_word[addr_cfg_pkg::listen_pos]        = (mode == addr_cfg_pkg::mode_listen_only);
    status_word[addr_cfg_pkg::talk_pos]          = (mode == addr_cfg_pkg::mode_talk_only);
    status_word[addr_cfg_pkg::addressed_pos]     = (mode == addr_cfg_pkg::mode_addressed);
    status_word[addr_cfg_pkg::latched_pos]       = (state == addr_cfg_pkg::st_run);
    status_word[addr_cfg_pkg::listen_chr_pos +: 8] =
      addr_char(addr_cfg_pkg::listen_base, stored_addr);
    status_word[addr_cfg_pkg::talk_chr_pos +: 8] =
      addr_char(addr_cfg_pkg::talk_base, stored_addr);
  end

  // ==========================================================
  // AXI write channels: capture address and data in either order
  // Ready drops while a response waits: one write at most is in flight
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_fire       = aw_held && w_held && !s_axi_bvalid;

  // Hold each write half until both are in, then release together
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      aw_addr_q <= 4'h0;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held   <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held   <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  // Write response decode
  always_comb begin
    if (aw_addr_q == addr_cfg_pkg::ctrl_reg_off) begin
      next_bresp = addr_cfg_pkg::resp_okay;
    end else if (aw_addr_q == addr_cfg_pkg::cfg_reg_off ||
                 aw_addr_q == addr_cfg_pkg::status_reg_off ||
                 aw_addr_q == addr_cfg_pkg::raw_reg_off) begin
      next_bresp = addr_cfg_pkg::resp_okay; // Read-only, write ignored
    end else begin
      next_bresp = addr_cfg_pkg::resp_slverr;
    end
  end

  // Write answer stands until bready; a new write waits behind it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= addr_cfg_pkg::resp_okay;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= next_bresp;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // AXI read channel decode
  // Unmapped offsets answer SLVERR with zero data
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    next_rresp = addr_cfg_pkg::resp_okay;
    if (s_axi_araddr == addr_cfg_pkg::cfg_reg_off) begin
      next_rdata = {27'h0, stored_addr};
    end else if (s_axi_araddr == addr_cfg_pkg::status_reg_off) begin
      next_rdata = status_word;
    end else if (s_axi_araddr == addr_cfg_pkg::raw_reg_off) begin
      next_rdata = {24'h0, addr_clamped, sw_sync};
    end else if (s_axi_araddr == addr_cfg_pkg::ctrl_reg_off) begin
      next_rdata = {31'h0, bus_enable};
    end else begin
      next_rdata = 32'h0000_0000;
      next_rresp = addr_cfg_pkg::resp_slverr;
    end
  end

  // Read answer registered; arready stays low until rready takes it
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= addr_cfg_pkg::resp_okay;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ---- sim/switch_panel.sv ----
// Behavioural model of the rear-panel switch bank
`timescale 1ns/1ps
module switch_panel (
  input  logic [6:0] setting_in,
  output logic       addr_switch_lsb_out,
  output logic [2:0] addr_switch_mid_out,
  output logic       addr_switch_msb_out,
  output logic       listen_only_select_out,
  output logic       talk_only_select_out
);
  // ====
  // Set position drives 1, first switch is the lsb
  assign addr_switch_lsb_out    = setting_in[0];
  assign addr_switch_mid_out    = setting_in[3:1];
  assign addr_switch_msb_out    = setting_in[4];
  assign listen_only_select_out = setting_in[5];
  assign talk_only_select_out   = setting_in[6];
endmodule

// ---- sim/bus_address_config_latch_asserts.sv ----
// Concurrent checks on the latched configuration and read handshake
`timescale 1ns/1ps
module bus_address_config_latch_asserts (
  input logic       clk_in,
  input logic       sys_rst_in,
  input logic [4:0] bus_address_out,
  input logic [7:0] listen_char_out,
  input logic [7:0] talk_char_out,
  input logic       listen_only_out,
  input logic       talk_only_out,
  input logic       addressed_out,
  input logic       config_valid_out,
  input logic       s_axi_arvalid,
  input logic       s_axi_arready,
  input logic       s_axi_rvalid
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  // ====
  // Stored address and derived characters
  chk_no_addr31: assert property (config_valid_out |-> bus_address_out != 5'h1f)
    else $error("invalid bus address stored");
  chk_listen_char: assert property (config_valid_out |->
    listen_char_out == (8'h20 | {3'h0, bus_address_out}))
    else $error("listen character wrong");
  chk_talk_char: assert property (config_valid_out |->
    talk_char_out == (8'h40 | {3'h0, bus_address_out}))
    else $error("talk character wrong");
  chk_addr_frozen: assert property (config_valid_out && $past(config_valid_out) |->
    $stable(bus_address_out))
    else $error("bus address moved after latch");
  chk_valid_sticky: assert property (config_valid_out |=> config_valid_out)
    else $error("latched flag dropped");
  // ====
  // Operating modes and read handshake
  chk_mode_excl: assert property ((listen_only_out || talk_only_out) |-> !addressed_out)
    else $error("addressed mode with selector set");
  chk_mode_pair: assert property (!(listen_only_out && talk_only_out))
    else $error("both only modes active");
  chk_mode_set: assert property ($rose(config_valid_out) |->
    $onehot({addressed_out, listen_only_out, talk_only_out}))
    else $error("no single mode after latch");
  chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  cov_latch: cover property ($rose(config_valid_out));
  cov_listen: cover property (listen_only_out);
  cov_talk: cover property (talk_only_out);
endmodule
bind bus_address_config_latch bus_address_config_latch_asserts chk_u (.clk_in, .sys_rst_in,
  .bus_address_out, .listen_char_out, .talk_char_out, .listen_only_out, .talk_only_out,
  .addressed_out, .config_valid_out, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- sim/bus_address_config_latch_tb_top.sv ----
// Self-checking bench for the bus address configuration latch
`timescale 1ns/1ps
module bus_address_config_latch_tb_top;
  typedef struct packed {logic [6:0] sw; logic [4:0] addr; logic [2:0] mode;} row_t;
  // Switches {to,lo,a5..a1}, stored address, modes {addressed,talk,listen}
  localparam row_t rows [11] = '{
    '{7'h00, 5'h00, 3'h4}, '{7'h01, 5'h01, 3'h4}, '{7'h10, 5'h10, 3'h4}, '{7'h06, 5'h06, 3'h4},
    '{7'h1f, 5'h1e, 3'h4}, '{7'h1e, 5'h1e, 3'h4}, '{7'h15, 5'h15, 3'h4}, '{7'h20, 5'h00, 3'h1},
    '{7'h3f, 5'h1e, 3'h1}, '{7'h43, 5'h03, 3'h2}, '{7'h63, 5'h03, 3'h1}};
  logic        clk_in, sys_rst_in, addr_switch_lsb_in, addr_switch_msb_in;
  logic        listen_only_select_in, talk_only_select_in;
  logic [2:0]  addr_switch_mid_in;
  logic [6:0]  sw;
  logic [4:0]  bus_address_out;
  logic [7:0]  listen_char_out, talk_char_out;
  logic        listen_only_out, talk_only_out, addressed_out, config_valid_out;
  logic [3:0]  s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int          bad_count, comparisons;
  switch_panel panel_u (.setting_in(sw), .addr_switch_lsb_out(addr_switch_lsb_in),
    .addr_switch_mid_out(addr_switch_mid_in), .addr_switch_msb_out(addr_switch_msb_in),
    .listen_only_select_out(listen_only_select_in), .talk_only_select_out(talk_only_select_in));
  bus_address_config_latch dut_u (.clk_in, .sys_rst_in, .addr_switch_lsb_in, .addr_switch_mid_in,
    .addr_switch_msb_in, .listen_only_select_in, .talk_only_select_in, .bus_address_out,
    .listen_char_out, .talk_char_out, .listen_only_out, .talk_only_out, .addressed_out,
    .config_valid_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  // ====
  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    bad_count++;
    finish_test();
  end
  // ====
  // Compare, verdict and bus tasks; every bus task ends just after a rising edge
  task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w, ra, rw, rb;
    aw = 1'b1;
    w = 1'b1;
    rb = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw || w) begin
      @(negedge clk_in);
      ra = s_axi_awready;
      rw = s_axi_wready;
      @(posedge clk_in);
      if (ra) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (rw) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!rb) begin
      @(negedge clk_in);
      rb = s_axi_bvalid;
      rsp = s_axi_bresp;
      @(posedge clk_in);
    end
    s_axi_bready <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic axi_rd(input logic [3:0] a);
    logic ra, rv;
    ra = 1'b0;
    rv = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!ra) begin
      @(negedge clk_in);
      ra = s_axi_arready;
      @(posedge clk_in);
    end
    s_axi_arvalid <= 1'b0;
    while (!rv) begin
      @(negedge clk_in);
      rv = s_axi_rvalid;
      rd = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk_in);
    end
    s_axi_rready <= 1'b0;
    @(posedge clk_in);
  endtask
  // Power cycle with new switch settings, waiting for the latch
  task automatic power_up(input logic [6:0] s);
    int n;
    sw <= s;
    sys_rst_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    cmp_val("valid in reset", 32'h0, {31'h0, config_valid_out});
    sys_rst_in <= 1'b0;
    n = 0;
    while (config_valid_out !== 1'b1 && n < 300) begin
      @(posedge clk_in);
      n++;
    end
    @(posedge clk_in);
  endtask
  task automatic check_row(input row_t r);
    logic [31:0] exp;
    exp = {8'h40 | {3'h0, r.addr}, 8'h20 | {3'h0, r.addr}, 4'h0, 1'b1, r.mode, 3'h0, r.addr};
    @(negedge clk_in);
    cmp_val("config valid", 32'h1, {31'h0, config_valid_out});
    cmp_val("bus address", {27'h0, r.addr}, {27'h0, bus_address_out});
    cmp_val("modes", 32'(r.mode), {29'h0, addressed_out, talk_only_out, listen_only_out});
    cmp_val("chars", {16'h0, exp[31:16]}, {16'h0, talk_char_out, listen_char_out});
    @(posedge clk_in);
    axi_rd(addr_cfg_pkg::status_reg_off);
    cmp_val("status", exp, rd);
    cmp_val("status resp", {30'h0, addr_cfg_pkg::resp_okay}, {30'h0, rsp});
    axi_rd(addr_cfg_pkg::raw_reg_off);
    cmp_val("raw", {24'h0, r.sw[4:0] == 5'h1f, r.sw}, rd);
  endtask
  // ====
  // Main sequence
  initial begin
    bad_count = 0;
    comparisons = 0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 40'h0;
    s_axi_wstrb <= 4'hf;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 5'h0;
    // First power_up call holds reset for the opening 4 cycles
    foreach (rows[i]) begin
      power_up(rows[i].sw);
      check_row(rows[i]);
    end
    // Switches moved while running leave the latched setting alone
    sw <= 7'h05;
    repeat (150) @(posedge clk_in);
    cmp_val("held address", 32'h3, {27'h0, bus_address_out});
    cmp_val("held listen", 32'h1, {31'h0, listen_only_out});
    axi_wr(addr_cfg_pkg::cfg_reg_off, 32'h0000001f);
    cmp_val("cfg write resp", {30'h0, addr_cfg_pkg::resp_okay}, {30'h0, rsp});
    axi_rd(addr_cfg_pkg::cfg_reg_off);
    cmp_val("cfg after write", 32'h3, rd);
    power_up(7'h05);
    check_row('{7'h05, 5'h05, 3'h4});
    // Bus enable gates the mode pin, status keeps the mode
    axi_rd(addr_cfg_pkg::ctrl_reg_off);
    cmp_val("ctrl reset", 32'h1, rd);
    axi_wr(addr_cfg_pkg::ctrl_reg_off, 32'h0);
    repeat (2) @(posedge clk_in);
    cmp_val("gated addressed", 32'h0, {31'h0, addressed_out});
    axi_rd(addr_cfg_pkg::status_reg_off);
    cmp_val("status mode", 32'h1, {31'h0, rd[10]});
    axi_wr(addr_cfg_pkg::ctrl_reg_off, 32'h1);
    repeat (2) @(posedge clk_in);
    cmp_val("ungated addressed", 32'h1, {31'h0, addressed_out});
    // Unmapped offsets answer with an error and leave the setting alone
    axi_rd(4'h2);
    cmp_val("unmapped rresp", {30'h0, addr_cfg_pkg::resp_slverr}, {30'h0, rsp});
    cmp_val("unmapped rdata", 32'h0, rd);
    axi_wr(4'h6, 32'h0);
    cmp_val("unmapped bresp", {30'h0, addr_cfg_pkg::resp_slverr}, {30'h0, rsp});
    repeat (2) @(posedge clk_in);
    cmp_val("addressed kept", 32'h1, {31'h0, addressed_out});
    finish_test();
  end
endmodule
